// ---- hw/exec_defs.vh ----
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH
// ==========================================================
// Status register bit positions
`define FLAG_C 3'd0
`define FLAG_Z 3'd1
`define FLAG_N 3'd2
`define FLAG_V 3'd3
`define FLAG_S 3'd4
`define FLAG_H 3'd5
`define FLAG_T 3'd6
`define FLAG_I 3'd7
// ==========================================================
// Operation codes on op_code
`define OP_NONE        5'h00
`define OP_BR_CLEAR    5'h01
`define OP_BR_EQ       5'h02
`define OP_BR_NE       5'h03
`define OP_BR_CS       5'h04
`define OP_BR_CC       5'h05
`define OP_BR_SH       5'h06
`define OP_BR_LO       5'h07
`define OP_BR_MI       5'h08
`define OP_BR_PL       5'h09
`define OP_BR_GE       5'h0A
`define OP_BR_LT       5'h0B
`define OP_BR_HS       5'h0C
`define OP_BR_HC       5'h0D
`define OP_BR_TS       5'h0E
`define OP_BR_IE       5'h0F
`define OP_BR_ID       5'h10
`define OP_MOVE        5'h11
`define OP_PAIR_COPY   5'h12
`define OP_LOAD_IMM    5'h13
`define OP_LD_PLAIN    5'h14
`define OP_LD_POSTINC  5'h15
`define OP_LD_PREDEC   5'h16
`define OP_LD_DISP     5'h17
// ==========================================================
// Pointer selects
`define PTR_X 2'd0
`define PTR_Y 2'd1
`define PTR_Z 2'd2
// Reset values
`define PC_RESET  16'h0000
`define PTR_RESET 16'h0000
`endif

// ---- hw/cond_branch_and_load_exec.v ----
`timescale 1ns/1ps
`include "exec_defs.vh"

module cond_branch_and_load_exec (
  input  wire        clk,          // Core clock, 125 MHz
  input  wire        resetn,       // Async reset, active low
  input  wire        op_valid,     // New operation offered
  input  wire [4:0]  op_code,      // Operation code
  input  wire [2:0]  flag_sel,     // Bit s for flag-clear branch
  input  wire [6:0]  branch_ofs,   // Signed offset k
  input  wire [4:0]  dst_sel,      // Destination register d
  input  wire [4:0]  src_sel,      // Source register r
  input  wire [7:0]  imm_val,      // Immediate K
  input  wire [1:0]  ptr_sel,      // Pointer X, Y or Z
  input  wire [5:0]  disp_val,     // Unsigned displacement q
  input  wire [7:0]  status_in,    // Current status register
  input  wire [7:0]  src_data,     // Value of register r
  input  wire [15:0] src_pair,     // Value of pair r+1:r
  input  wire [15:0] ptr_x,        // Current X pointer
  input  wire [15:0] ptr_y,        // Current Y pointer
  input  wire [15:0] ptr_z,        // Current Z pointer
  input  wire [7:0]  mem_rdata,    // Data memory read data
  output reg         op_ready,     // Block can take an operation
  output reg  [15:0] pc_out,       // Program counter
  output reg         mem_rd,       // Data memory read strobe
  output reg  [15:0] mem_addr,     // Data memory address
  output reg         reg_we,       // Write register d
  output reg         pair_we,      // Write pair d+1:d
  output reg  [4:0]  reg_waddr,    // Destination index
  output reg  [15:0] reg_wdata,    // Write data (byte in low bits)
  output reg         ptr_we,       // Write pointer back
  output reg  [1:0]  ptr_wsel,     // Pointer written
  output reg  [15:0] ptr_wdata,    // New pointer value
  output reg         status_we     // Status write, never raised here
);

  // ==========================================================
  // Sequencer states
  localparam ST_IDLE   = 2'd0;
  localparam ST_BRANCH = 2'd1;
  localparam ST_LOAD   = 2'd2;

  // Sequencer state and operands held across the second cycle
  reg  [1:0]  state_r;
  reg  [15:0] target_r;
  reg  [4:0]  load_dst_r;

  // Decode results, combinational
  reg         take;
  reg  [15:0] ptr_cur;
  reg  [15:0] ptr_new;
  reg  [15:0] addr_nxt;
  wire [15:0] ofs_ext;
  wire        is_branch;
  wire        is_load;

  // Sign-extended k; the target add wraps at 16 bits like the pc itself
  assign ofs_ext   = {{9{branch_ofs[6]}}, branch_ofs};
  assign is_branch = (op_code >= `OP_BR_CLEAR) && (op_code <= `OP_BR_ID);
  assign is_load   = (op_code >= `OP_LD_PLAIN) && (op_code <= `OP_LD_DISP);

  // ==========================================================
  // Branch condition decode
  // Bit S is reached only through the clear form; no named branch tests it
  always @* begin
    case (op_code)
      `OP_BR_CLEAR: take = ~status_in[flag_sel];
      `OP_BR_EQ:    take = status_in[`FLAG_Z];
      `OP_BR_NE:    take = ~status_in[`FLAG_Z];
      `OP_BR_CS:    take = status_in[`FLAG_C];
      `OP_BR_LO:    take = status_in[`FLAG_C];
      `OP_BR_CC:    take = ~status_in[`FLAG_C];
      `OP_BR_SH:    take = ~status_in[`FLAG_C];
      `OP_BR_MI:    take = status_in[`FLAG_N];
      `OP_BR_PL:    take = ~status_in[`FLAG_N];
      `OP_BR_GE:    take = ~(status_in[`FLAG_N] ^ status_in[`FLAG_V]);
      `OP_BR_LT:    take = status_in[`FLAG_N] ^ status_in[`FLAG_V];
      `OP_BR_HS:    take = status_in[`FLAG_H];
      `OP_BR_HC:    take = ~status_in[`FLAG_H];
      `OP_BR_TS:    take = status_in[`FLAG_T];
      `OP_BR_IE:    take = status_in[`FLAG_I];
      `OP_BR_ID:    take = ~status_in[`FLAG_I];
      default:      take = 1'b0;
    endcase
  end

  // ==========================================================
  // Pointer select and address forming
  always @* begin
    case (ptr_sel)
      `PTR_X:  ptr_cur = ptr_x;
      `PTR_Y:  ptr_cur = ptr_y;
      default: ptr_cur = ptr_z;
    endcase
    // Defaults: pointer kept, address is the pointer itself
    ptr_new  = ptr_cur;
    addr_nxt = ptr_cur;
    case (op_code)
      `OP_LD_POSTINC: ptr_new = ptr_cur + 16'h0001;
      `OP_LD_PREDEC: begin
        ptr_new  = ptr_cur - 16'h0001;
        addr_nxt = ptr_new;
      end
      `OP_LD_DISP:    addr_nxt = ptr_y + {10'h000, disp_val};
      default:        addr_nxt = ptr_cur;
    endcase
  end

  // ==========================================================
  // Sequencer: one cycle for simple ops, two for taken branch and loads
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Constants only, so no data path feeds the reset branch
      state_r    <= ST_IDLE;
      op_ready   <= 1'b1;
      pc_out     <= `PC_RESET;
      target_r   <= `PC_RESET;
      load_dst_r <= 5'h00;
      mem_rd     <= 1'b0;
      mem_addr   <= `PTR_RESET;
      reg_we     <= 1'b0;
      pair_we    <= 1'b0;
      reg_waddr  <= 5'h00;
      reg_wdata  <= 16'h0000;
      ptr_we     <= 1'b0;
      ptr_wsel   <= 2'd0;
      ptr_wdata  <= `PTR_RESET;
      status_we  <= 1'b0;
    end else begin
      // Strobes default low; no path here ever writes status
      reg_we    <= 1'b0;
      pair_we   <= 1'b0;
      ptr_we    <= 1'b0;
      mem_rd    <= 1'b0;
      status_we <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (op_valid) begin
            if (is_branch) begin
              if (take) begin
                // Taken: hold one extra cycle before redirect
                target_r <= pc_out + ofs_ext + 16'h0001;
                state_r  <= ST_BRANCH;
                op_ready <= 1'b0;
              end else begin
                pc_out <= pc_out + 16'h0001;
              end
            end else if (is_load) begin
              // Pointer writeback lands with the read address
              mem_rd     <= 1'b1;
              mem_addr   <= addr_nxt;
              load_dst_r <= dst_sel;
              // Plain and displaced forms write no pointer back
              ptr_we     <= (op_code == `OP_LD_POSTINC) ||
                            (op_code == `OP_LD_PREDEC);
              ptr_wsel   <= ptr_sel;
              ptr_wdata  <= ptr_new;
              state_r    <= ST_LOAD;
              op_ready   <= 1'b0;
            end else begin
              // Unlisted codes also step the pc, like a no-op
              pc_out <= pc_out + 16'h0001;
              case (op_code)
                // Byte results ride in the low half of reg_wdata
                `OP_MOVE: begin
                  reg_we    <= 1'b1;
                  reg_waddr <= dst_sel;
                  reg_wdata <= {8'h00, src_data};
                end
                `OP_PAIR_COPY: begin
                  pair_we   <= 1'b1;
                  reg_waddr <= dst_sel;
                  reg_wdata <= src_pair;
                end
                `OP_LOAD_IMM: begin
                  reg_we    <= 1'b1;
                  reg_waddr <= dst_sel;
                  reg_wdata <= {8'h00, imm_val};
                end
                default: ;
              endcase
            end
          end
        end
        ST_BRANCH: begin
          // Second cycle of a taken branch: redirect
          pc_out   <= target_r;
          state_r  <= ST_IDLE;
          op_ready <= 1'b1;
        end
        ST_LOAD: begin
          // Memory answers one cycle after the strobe
          // A slower memory would need a wait input here
          reg_we    <= 1'b1;
          reg_waddr <= load_dst_r;
          reg_wdata <= {8'h00, mem_rdata};
          pc_out    <= pc_out + 16'h0001;
          state_r   <= ST_IDLE;
          op_ready  <= 1'b1;
        end
        default: begin
          // Unused state code: recover to idle
          state_r  <= ST_IDLE;
          op_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule // cond_branch_and_load_exec

// ---- test/exec_port_checker_assertions.sv ----
`timescale 1ns/1ps
`include "exec_defs.vh"
// ==================================================
// Port checker for the branch and load executor
module exec_port_checker (
  input wire        clk,        // Core clock
  input wire        resetn,     // Reset
  input wire        op_valid,   // Offer
  input wire [4:0]  op_code,    // Operation
  input wire [6:0]  branch_ofs, // Offset k
  input wire [7:0]  status_in,  // Flags
  input wire [15:0] ptr_y,      // Y pointer
  input wire [5:0]  disp_val,   // Displacement
  input wire        op_ready,   // Idle
  input wire [15:0] pc_out,     // PC
  input wire        mem_rd,     // Read strobe
  input wire [15:0] mem_addr,   // Address
  input wire        reg_we,     // Byte write
  input wire        ptr_we,     // Pointer write
  input wire        status_we   // Flag write
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Offset kept as a wire so that its value at take time can be recalled
  wire        take = op_valid && op_ready;
  wire [15:0] kx   = {{9{branch_ofs[6]}}, branch_ofs};
  wire        ld   = take && op_code >= `OP_LD_PLAIN && op_code <= `OP_LD_DISP;
  // Endings of an untaken and a taken branch
  sequence fall_thru;
    op_ready && pc_out == $past(pc_out) + 16'h0001;
  endsequence
  sequence jump;
    !op_ready ##1 op_ready && pc_out == $past(pc_out, 2) + $past(kx, 2) + 16'h0001;
  endsequence
  chk_flags_kept: assert property (!status_we) else $error("flags written");
  chk_eq_jump: assert property (take && op_code == `OP_BR_EQ && status_in[1] |=> jump)
    else $error("equal branch");
  chk_ne_fall: assert property (take && op_code == `OP_BR_NE && status_in[1] |=> fall_thru)
    else $error("not-equal fall");
  chk_lt_jump: assert property (take && op_code == `OP_BR_LT && (status_in[2] ^ status_in[3])
    |=> jump) else $error("signed lt branch");
  chk_id_fall: assert property (take && op_code == `OP_BR_ID && status_in[7] |=> fall_thru)
    else $error("irq-off fall");
  chk_move_once: assert property (take && op_code == `OP_MOVE |=> reg_we ##0 fall_thru)
    else $error("move timing");
  chk_load_two: assert property (ld |=> mem_rd && !op_ready ##1 reg_we && op_ready)
    else $error("load timing");
  chk_disp_addr: assert property (take && op_code == `OP_LD_DISP
    |=> mem_addr == $past(ptr_y) + $past(disp_val) && !ptr_we) else $error("disp address");
  chk_busy_once: assert property (!op_ready |=> op_ready) else $error("busy too long");
endmodule // exec_port_checker
bind cond_branch_and_load_exec exec_port_checker u_chk (.*);

// ---- test/tb_cond_branch_and_load_exec.sv ----
`timescale 1ns/1ps
`include "exec_defs.vh"
// ==================================================
// Bench for the branch and load executor
module tb_cond_branch_and_load_exec;
  reg         clk = 1'b0, resetn = 1'b0, op_valid = 1'b0;
  reg  [4:0]  op_code = 5'h00, dst_sel = 5'h00;
  reg  [2:0]  flag_sel = 3'h3;
  reg  [6:0]  branch_ofs = 7'h00, k;
  reg  [7:0]  imm_val = 8'h00, status_in = 8'h00, src_data = 8'h00, mem_rdata = 8'h00;
  reg  [1:0]  ptr_sel = 2'h0;
  reg  [5:0]  disp_val = 6'h3F;
  reg  [15:0] src_pair = 16'h0000, ptr_x = 16'h1230, ptr_y = 16'h4560, ptr_z = 16'h0000;
  reg  [15:0] pc_e, a_e, w_e;
  reg  [20:0] e;
  wire        op_ready, mem_rd, reg_we, pair_we, ptr_we, status_we;
  wire [15:0] pc_out, mem_addr, reg_wdata, ptr_wdata;
  wire [4:0]  reg_waddr;
  wire [1:0]  ptr_wsel;
  integer     mismatches = 0, num_checks = 0, i, n, p;
  // Operation, flags that take it, flags that do not (bit 3 chosen for the clear form)
  function [20:0] btab;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    btab = {`OP_BR_CLEAR, 16'h0008};
        4'h1:    btab = {`OP_BR_EQ, 16'h0200};
        4'h2:    btab = {`OP_BR_NE, 16'h0002};
        4'h3:    btab = {`OP_BR_CS, 16'h0100};
        4'h4:    btab = {`OP_BR_CC, 16'h0001};
        4'h5:    btab = {`OP_BR_SH, 16'h0001};
        4'h6:    btab = {`OP_BR_LO, 16'h0100};
        4'h7:    btab = {`OP_BR_MI, 16'h0400};
        4'h8:    btab = {`OP_BR_PL, 16'h0004};
        4'h9:    btab = {`OP_BR_GE, 16'h0C04};
        4'hA:    btab = {`OP_BR_LT, 16'h040C};
        4'hB:    btab = {`OP_BR_HS, 16'h2000};
        4'hC:    btab = {`OP_BR_HC, 16'h0020};
        4'hD:    btab = {`OP_BR_TS, 16'h4000};
        4'hE:    btab = {`OP_BR_IE, 16'h8000};
        default: btab = {`OP_BR_ID, 16'h0080};
      endcase
    end
  endfunction
  always #4 clk = ~clk; // 125 MHz
  cond_branch_and_load_exec uut (.src_sel(5'h00), .*);
  // ==================================================
  // Verdict, comparison and offer
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Waits for idle under a bound; results are read 1 ns after the taking edge
  task offer(input [4:0] op);
    begin
      n = 0;
      while (op_ready !== 1'b1 && n < 8) begin
        @(posedge clk);
        n = n + 1;
      end
      if (op_ready !== 1'b1) begin
        mismatches = mismatches + 1;
        conclude;
      end
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
    end
  endtask
  // ==================================================
  // Scenarios
  task t_moves;
    begin
      src_data <= 8'h5A;
      src_pair <= 16'hBEEF;
      imm_val <= 8'hC3;
      dst_sel <= 5'h1E;
      status_in <= 8'hFF;
      offer(`OP_MOVE);
      chk({reg_we, reg_waddr, reg_wdata[7:0], pc_out[1:0]}, 16'hF969);
      offer(`OP_PAIR_COPY);
      chk(reg_wdata, 16'hBEEF);
      chk({pair_we, op_ready, pc_out[13:0]}, 16'hC002);
      offer(`OP_LOAD_IMM);
      chk({reg_we, reg_wdata[7:0], pc_out[6:0]}, 16'hE183);
      chk(status_we, 16'h0000);
      offer(5'h1F);
      chk({reg_we, pair_we, pc_out[13:0]}, 16'h0004);
      pc_e = 16'h0004;
      $display("moves done");
    end
  endtask
  task t_branches;
    begin
      for (i = 0; i < 32; i = i + 1) begin
        @(posedge clk);
        e = btab(i[4:1]);
        k = i[1] ? 7'h40 : 7'h3F; // Both ends of the offset range
        status_in <= i[0] ? e[7:0] : e[15:8];
        branch_ofs <= k;
        offer(e[20:16]);
        if (!i[0]) begin
          chk(op_ready, 16'h0000);
          @(posedge clk);
          #1;
          pc_e = pc_e + {{9{k[6]}}, k} + 16'h0001;
        end else pc_e = pc_e + 16'h0001;
        chk(pc_out, pc_e);
      end
      $display("branches done");
    end
  endtask
  // Plain, post-increment and pre-decrement loads over X, Y and Z (Z wraps), displaced loads always off Y
  task t_loads;
    begin
      for (i = 0; i < 12; i = i + 1) begin
        @(posedge clk);
        p = i % 3;
        ptr_sel <= p[1:0];
        dst_sel <= i[4:0];
        mem_rdata <= 8'hA0 + i[7:0];
        a_e = (p == 0) ? ptr_x : (p == 1) ? ptr_y : ptr_z;
        w_e = (i / 3 == 1) ? a_e + 16'h0001 : a_e - 16'h0001;
        if (i / 3 == 2) a_e = w_e;
        if (i / 3 == 3) a_e = ptr_y + 16'h003F;
        offer(`OP_LD_PLAIN + i[4:0] / 5'd3);
        chk({mem_rd, op_ready, ptr_we}, (i / 3 == 1 || i / 3 == 2) ? 16'h0005 : 16'h0004);
        chk(mem_addr, a_e);
        if (i / 3 == 1 || i / 3 == 2) chk(ptr_wdata, w_e);
        if (i / 3 == 1 || i / 3 == 2) chk(ptr_wsel, p);
        @(posedge clk);
        #1;
        chk({reg_we, reg_waddr, reg_wdata[7:0]}, {3'h1, i[4:0], 8'hA0 + i[7:0]});
        pc_e = pc_e + 16'h0001;
        chk(pc_out, pc_e);
      end
      $display("loads done");
    end
  endtask
  // Main sequence
  initial begin
    pc_e = 16'h0000;
    repeat (6) @(posedge clk);
    chk({op_ready, pc_out[14:0]}, 16'h8000);
    resetn <= 1'b1;
    t_moves;
    t_branches;
    t_loads;
    conclude;
  end
endmodule // tb_cond_branch_and_load_exec
